// [core/octq_top.sv]
`timescale 1ns/1ps
module octq_top (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire octq_pkg::octq_bus_t i_bus,
  output logic [31:0]             o_rdata,
  input  wire octq_pkg::octq_meas_t i_meas,
  input  wire logic               i_external_shutdown_header_n,
  input  wire logic [5:0]         i_pwm,
  output logic [5:0]              o_pwm,
  output logic                    o_pwm_enable,
  output logic                    o_overcurrent_trip_flag,
  output logic                    o_irq
);
  import octq_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_TRIPPED = 3'b100
  } octq_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Magnitude compare helper, used for every measured phase
  function automatic logic over_limit(input logic signed [CUR_W-1:0] cur,
                                      input logic [CUR_W-1:0] lim);
    logic signed [CUR_W:0] pos;
    logic signed [CUR_W:0] neg;
    pos = $signed({1'b0, lim});
    neg = -pos;
    over_limit = ($signed({cur[CUR_W-1], cur}) >= pos) ||
                 ($signed({cur[CUR_W-1], cur}) <= neg);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // External shutdown pin synchroniser
  // Reset to the idle level so no false shutdown event follows reset
  logic ext_s1_q;
  logic ext_s2_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
    end else begin
      ext_s1_q <= i_external_shutdown_header_n;
      ext_s2_q <= ext_s1_q;
    end
  end
  logic ext_active;
  assign ext_active = ~ext_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register access helpers
  function automatic logic wr_hit(input octq_bus_t bus, input logic [3:0] idx);
    wr_hit = bus.wr && (bus.addr == idx);
  endfunction

  function automatic logic rd_hit(input octq_bus_t bus, input logic [3:0] idx);
    rd_hit = bus.rd && (bus.addr == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Settings and control
  logic [CUR_W-1:0] limit_q, limit_d;
  logic [CNT_W-1:0] div_q, div_d;
  logic [CNT_W-1:0] win_q, win_d;
  logic [CNT_W-1:0] thr_q, thr_d;
  logic             pwm_en_q, pwm_en_d;
  logic             clr_req;
  logic             trip_flag;
  logic             raw_cmp;
  logic             qualified;

  always_comb begin
    limit_d  = limit_q;
    div_d    = div_q;
    win_d    = win_q;
    thr_d    = thr_q;
    pwm_en_d = pwm_en_q;
    clr_req  = 1'b0;
    // Trip clear is a strobe, not a stored bit, so it always reads back as 0
    if (wr_hit(i_bus, REG_CTRL)) begin
      clr_req  = i_bus.wdata[CTRL_TRIP_CLR];
      pwm_en_d = i_bus.wdata[CTRL_PWM_EN];
    end
    if (wr_hit(i_bus, REG_LIMIT)) begin
      limit_d = i_bus.wdata[CUR_W-1:0];
    end
    if (wr_hit(i_bus, REG_DIVIDER)) begin
      div_d = i_bus.wdata[CNT_W-1:0];
    end
    if (wr_hit(i_bus, REG_WINDOW)) begin
      win_d = i_bus.wdata[CNT_W-1:0];
    end
    if (wr_hit(i_bus, REG_THRESH)) begin
      thr_d = i_bus.wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      limit_q  <= CUR_LIMIT_RST;
      div_q    <= DIVIDER_RST;
      win_q    <= WINDOW_RST;
      thr_q    <= THRESH_RST;
      pwm_en_q <= 1'b0;
    end else begin
      limit_q  <= limit_d;
      div_q    <= div_d;
      win_q    <= win_d;
      thr_q    <= thr_d;
      pwm_en_q <= pwm_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event status and interrupt enable
  logic [ST_W-1:0]  irq_st_q, irq_st_d;
  logic [ST_W-1:0]  irq_en_q, irq_en_d;

  always_comb begin
    irq_st_d = irq_st_q;
    irq_en_d = irq_en_q;
    if (wr_hit(i_bus, REG_IRQ_EN)) begin
      irq_en_d = i_bus.wdata[ST_W-1:0];
    end
    if (wr_hit(i_bus, REG_IRQ_CLR)) begin
      irq_st_d = irq_st_q & ~i_bus.wdata[ST_W-1:0];
    end
    // Events set after the clear so a same-cycle event is never lost
    irq_st_d[ST_TRIP] = irq_st_d[ST_TRIP] | (qualified & ~trip_flag);
    irq_st_d[ST_EXT]  = irq_st_d[ST_EXT] | ext_active;
    irq_st_d[ST_QUAL] = irq_st_d[ST_QUAL] | qualified;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_st_q <= '0;
      irq_en_q <= '0;
    end else begin
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: registered, and zero in every cycle that does not follow a read
  logic [31:0]      rdata_q, rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_hit(i_bus, REG_CTRL)) begin
      rdata_d[CTRL_PWM_EN] = pwm_en_q;
    end
    if (rd_hit(i_bus, REG_LIMIT)) begin
      rdata_d[CUR_W-1:0] = limit_q;
    end
    if (rd_hit(i_bus, REG_DIVIDER)) begin
      rdata_d[CNT_W-1:0] = div_q;
    end
    if (rd_hit(i_bus, REG_WINDOW)) begin
      rdata_d[CNT_W-1:0] = win_q;
    end
    if (rd_hit(i_bus, REG_THRESH)) begin
      rdata_d[CNT_W-1:0] = thr_q;
    end
    if (rd_hit(i_bus, REG_STATUS)) begin
      rdata_d[ST_TRIP] = trip_flag;
      rdata_d[ST_EXT]  = ext_active;
      rdata_d[ST_QUAL] = raw_cmp;
      rdata_d[ST_STICKY_LSB+ST_W-1:ST_STICKY_LSB] = irq_st_q;
    end
    if (rd_hit(i_bus, REG_IRQ_EN)) begin
      rdata_d[ST_W-1:0] = irq_en_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator stage: one limit for shunt and sensor paths, both polarities
  // Registered once to cut the path from the measurement inputs; costs one cycle
  logic raw_q, raw_d;
  always_comb begin
    raw_d = over_limit(i_meas.shunt_u, limit_q) |
            over_limit(i_meas.shunt_v, limit_q) |
            over_limit(i_meas.sensor_u, limit_q) |
            over_limit(i_meas.sensor_v, limit_q);
  end
  assign raw_cmp = raw_q;

  ////////////////////////////////////////////////////////////////////////////
  // Qualifier: divided sample strobe, windowed active count
  // A window holds win_q+1 samples; a setting of 0 gives one-sample windows
  logic [CNT_W-1:0] pre_q, pre_d;
  logic [CNT_W-1:0] wpos_q, wpos_d;
  logic [CNT_W-1:0] hits_q, hits_d;
  logic             qual_q, qual_d;
  logic             sample;

  always_comb begin
    pre_d  = pre_q;
    wpos_d = wpos_q;
    hits_d = hits_q;
    qual_d = 1'b0;
    sample = 1'b0;
    if (pre_q >= div_q) begin
      pre_d  = '0;
      sample = 1'b1;
    end else begin
      pre_d = pre_q + 8'h01;
    end
    if (sample) begin
      if (wpos_q >= win_q) begin
        wpos_d = '0;
        hits_d = {7'h00, raw_q};
      end else begin
        wpos_d = wpos_q + 8'h01;
        // Saturate so a long window cannot wrap the count
        if (raw_q && hits_q != 8'hff) begin
          hits_d = hits_q + 8'h01;
        end
      end
      // Zero threshold would trip on any sample; treat it as one
      qual_d = raw_q && (hits_d >= ((thr_q == 8'h00) ? 8'h01 : thr_q));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      raw_q  <= 1'b0;
      pre_q  <= '0;
      wpos_q <= '0;
      hits_q <= '0;
      qual_q <= 1'b0;
    end else begin
      raw_q  <= raw_d;
      pre_q  <= pre_d;
      wpos_q <= wpos_d;
      hits_q <= hits_d;
      qual_q <= qual_d;
    end
  end
  assign qualified = qual_q;

  ////////////////////////////////////////////////////////////////////////////
  // Trip latch
  octq_state_t state_q, state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:    if (pwm_en_q) state_d = ST_RUN;
      ST_RUN: begin
        if (qualified) state_d = ST_TRIPPED;
        else if (!pwm_en_q) state_d = ST_IDLE;
      end
      ST_TRIPPED: begin
        // A clear in the cycle of a qualified pulse is refused: the trip wins
        // Hold off regardless of current level until software clears
        if (clr_req && !qualified) state_d = pwm_en_q ? ST_RUN : ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  assign trip_flag = (state_q == ST_TRIPPED);

  ////////////////////////////////////////////////////////////////////////////
  // PWM gating; external shutdown bypasses the qualifier entirely
  // Gate and data share one edge so the enable never leads the PWM lines
  logic [5:0] pwm_q, pwm_d;
  logic       gate_q, gate_d;
  always_comb begin
    gate_d = (state_q == ST_RUN) && !qualified && !ext_active;
    pwm_d  = gate_d ? i_pwm : 6'h00;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pwm_q  <= 6'h00;
      gate_q <= 1'b0;
    end else begin
      pwm_q  <= pwm_d;
      gate_q <= gate_d;
    end
  end

  assign o_pwm                   = pwm_q;
  assign o_pwm_enable            = gate_q;
  assign o_overcurrent_trip_flag = trip_flag;
  assign o_rdata                 = rdata_q;
  assign o_irq                   = |(irq_st_q & irq_en_q);

endmodule // octq_top

// [core/octq_pkg.sv]
package octq_pkg;

  localparam int CUR_W = 16;
  localparam int CNT_W = 8;

  // Current scale: 1 A is 0x0100 counts (8.8 fixed point)
  localparam logic [CUR_W-1:0] CUR_LIMIT_RST  = 16'h0800;
  localparam logic [CNT_W-1:0] DIVIDER_RST    = 8'h14;
  localparam logic [CNT_W-1:0] WINDOW_RST     = 8'h1e;
  localparam logic [CNT_W-1:0] THRESH_RST     = 8'h12;

  // Register offsets
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_LIMIT     = 4'h1;
  localparam logic [3:0] REG_DIVIDER   = 4'h2;
  localparam logic [3:0] REG_WINDOW    = 4'h3;
  localparam logic [3:0] REG_THRESH    = 4'h4;
  localparam logic [3:0] REG_STATUS    = 4'h5;
  localparam logic [3:0] REG_IRQ_CLR   = 4'h6;
  localparam logic [3:0] REG_IRQ_EN    = 4'h7;

  // Control bits
  localparam int CTRL_TRIP_CLR = 0;
  localparam int CTRL_PWM_EN   = 1;

  // Status / interrupt bits
  localparam int ST_TRIP   = 0;
  localparam int ST_EXT    = 1;
  localparam int ST_QUAL   = 2;
  localparam int ST_W      = 3;
  // Sticky event bits sit in the status word from this bit upward
  localparam int ST_STICKY_LSB = 8;

  typedef struct packed {
    logic signed [CUR_W-1:0] shunt_u;
    logic signed [CUR_W-1:0] shunt_v;
    logic signed [CUR_W-1:0] sensor_u;
    logic signed [CUR_W-1:0] sensor_v;
  } octq_meas_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } octq_bus_t;

endpackage

// [tb/octq_sva.sv]
`timescale 1ns/1ps
module octq_sva
  import octq_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_rst,
  input wire octq_bus_t    i_bus,
  input wire logic [31:0]  o_rdata,
  input wire octq_meas_t   i_meas,
  input wire logic         i_external_shutdown_header_n,
  input wire logic [5:0]   i_pwm,
  input wire logic [5:0]   o_pwm,
  input wire logic         o_pwm_enable,
  input wire logic         o_overcurrent_trip_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic clr;
  assign clr = i_bus.wr && i_bus.addr == REG_CTRL && i_bus.wdata[CTRL_TRIP_CLR];
  property p_gate; o_overcurrent_trip_flag |-> o_pwm == 6'h00; endproperty
  a_gate: assert property (p_gate) else $error("pwm live while tripped");
  property p_en; o_overcurrent_trip_flag |-> !o_pwm_enable; endproperty
  a_en: assert property (p_en) else $error("enable high while tripped");
  property p_hold; o_overcurrent_trip_flag && !clr |=> o_overcurrent_trip_flag; endproperty
  a_hold: assert property (p_hold) else $error("trip dropped without clear");
  // Quiet current for three cycles means no qualifier pulse can still be in flight
  property p_clr; clr && i_meas == 64'h0 && $past(i_meas) == 64'h0
    && $past(i_meas, 2) == 64'h0 |=> !o_overcurrent_trip_flag; endproperty
  a_clr: assert property (p_clr) else $error("clear not taken");
  property p_cause; $rose(o_overcurrent_trip_flag) |-> $past(i_meas, 3) != 64'h0; endproperty
  a_cause: assert property (p_cause) else $error("trip without current");
  property p_ext; !i_external_shutdown_header_n [*3] |=> o_pwm == 6'h00; endproperty
  a_ext: assert property (p_ext) else $error("external stop ignored");
  property p_pass; o_pwm != 6'h00 |-> o_pwm == $past(i_pwm); endproperty
  a_pass: assert property (p_pass) else $error("pwm not a copy of input");
  property p_rd; !i_bus.rd || i_bus.addr > REG_IRQ_EN |=> o_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside its slot");
endmodule // octq_sva

bind octq_top octq_sva u_sva (.i_clk, .i_rst, .i_bus, .o_rdata, .i_meas,
  .i_external_shutdown_header_n, .i_pwm, .o_pwm, .o_pwm_enable, .o_overcurrent_trip_flag);

// [tb/octq_plant.sv]
`timescale 1ns/1ps
module octq_plant
  import octq_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic signed [CUR_W-1:0] i_level,
  input  wire logic                    i_sensor,
  output octq_meas_t                   o_meas,
  output logic [5:0]                   o_pwm
);
  logic [5:0] pat_q = 6'h15;
  // Pattern moves every cycle so a stuck or delayed gate shows up
  always_ff @(posedge i_clk) begin
    pat_q <= pat_q + 6'h01;
  end
  assign o_pwm = pat_q;
  always_comb begin
    o_meas = '0;
    if (i_sensor) begin
      o_meas.sensor_v = i_level;
    end else begin
      o_meas.shunt_u = i_level;
    end
  end
endmodule // octq_plant

// [tb/octq_top_tb.sv]
`timescale 1ns/1ps
module octq_top_tb;
  import octq_pkg::*;
  logic                    clk, rst, ext_n, sensor, pwm_en, flag, irq;
  logic signed [CUR_W-1:0] level;
  octq_bus_t               bus;
  octq_meas_t              meas;
  logic [5:0]              pwm_in, pwm;
  logic [31:0]             rdata;
  int                      fail_count, comparisons;

  octq_plant u_plant (.i_clk(clk), .i_level(level), .i_sensor(sensor), .o_meas(meas),
    .o_pwm(pwm_in));
  octq_top u_dut (.i_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata), .i_meas(meas),
    .i_external_shutdown_header_n(ext_n), .i_pwm(pwm_in), .o_pwm(pwm),
    .o_pwm_enable(pwm_en), .o_overcurrent_trip_flag(flag), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    // Read data stand only in the cycle right after the strobe
    #1 chk(rdata & m, e);
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task report_and_stop;
    $display("mismatches=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Holds the level until the trip shows, then removes it and tests the latch
  task t_trip(input logic s, input logic signed [CUR_W-1:0] l);
    int i;
    @(posedge clk);
    sensor <= s;
    level <= l;
    for (i = 0; i < 60 && flag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(flag, 1'b1);
    chk(pwm, 6'h00);
    @(posedge clk);
    level <= 16'sh0000;
    settle(20);
    chk(flag, 1'b1);
    rd(REG_STATUS, 32'h101, 32'h101);
    wr(REG_CTRL, 32'h3);
    settle(3);
    chk({flag, pwm_en}, 2'b01);
  endtask
  task t_quiet(input logic [31:0] th, input logic signed [CUR_W-1:0] l);
    wr(REG_THRESH, th);
    level <= l;
    settle(40);
    chk(flag, 1'b0);
    @(posedge clk);
    level <= 16'sh0000;
    wr(REG_THRESH, 32'h2);
  endtask
  task t_irq;
    wr(REG_IRQ_EN, 32'h1);
    settle(2);
    chk(irq, 1'b1);
    wr(REG_IRQ_EN, 32'h0);
    settle(2);
    chk(irq, 1'b0);
    wr(REG_IRQ_EN, 32'h1);
    wr(REG_IRQ_CLR, 32'h7);
    settle(2);
    chk(irq, 1'b0);
  endtask
  task t_ext;
    @(posedge clk);
    ext_n <= 1'b0;
    settle(5);
    chk({pwm, flag}, 7'h00);
    rd(REG_STATUS, 32'h202, 32'h203);
    @(posedge clk);
    ext_n <= 1'b1;
    settle(5);
    chk(pwm_en, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    bus = '0;
    level = 16'sh0000;
    sensor = 1'b0;
    ext_n = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk({pwm, pwm_en, flag, irq}, 9'h000);
    rd(REG_LIMIT, 32'h800, 32'hffff);
    rd(REG_DIVIDER, 32'h14, 32'hff);
    rd(REG_WINDOW, 32'h1e, 32'hff);
    rd(REG_THRESH, 32'h12, 32'hff);
    rd(4'h9, 32'h0, 32'hffffffff);
    wr(REG_DIVIDER, 32'h0);
    wr(REG_WINDOW, 32'h3);
    wr(REG_THRESH, 32'h2);
    wr(REG_CTRL, 32'h2);
    settle(3);
    chk(pwm_en, 1'b1);
    t_quiet(32'h2, 16'sh07ff);
    t_quiet(32'h5, 16'sh0900);
    t_trip(1'b0, 16'sh0800);
    t_irq();
    t_trip(1'b1, -16'sh0800);
    t_ext();
    report_and_stop();
  end
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
endmodule // octq_top_tb
